// >>> ofsr_fault_report.sv
// output driver protection, fault flags and status alarm reporting
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
// Operation
// - each driver has own protection; overcurrent or overtemperature forces its output off
// - a driver fault never halts the block; only the fault location is reported
// - a protection trip is sent as a status alarm record to the ladder controller
// - alarm data bit one means that bit's driver detected an error, zero none
// - alarm numbers 5, 6, 7 report output bytes base plus 5, 6, 7
// - alarm bit n maps onto output bit n of its byte
// - record carries type 0, group 0 to 23, path 1 to 5 or 9, slot 1
// - safety variant uses same layout relative to the safety output base
module ofsr_fault_report
   import ofsr_pkg::*;
#(
   parameter int NBYTE = OFSR_NBYTE     // supervised output bytes
) (
   input wire logic i_mclk,                      // 10 MHz clock
   input wire logic i_sys_rst,                   // async reset, active high
   input wire logic [3:0] i_addr,                // register address
   input wire logic [31:0] i_wdata,              // register write data
   input wire logic i_wr,                        // write strobe
   input wire logic i_rd,                        // read strobe
   output logic [31:0] o_rdata,                  // read data, cycle after i_rd
   input wire logic [NBYTE*8-1:0] i_do_cmd,      // commanded output bits
   input wire logic [NBYTE*8-1:0] i_ocp,         // overcurrent sense per driver
   input wire logic [NBYTE*8-1:0] i_otp,         // overtemperature sense per driver
   output logic [NBYTE*8-1:0] o_do_drive,        // driver enables after protection
   output logic [NBYTE*8-1:0] o_fault_flags,     // live fault flags
   output logic o_alarm_valid,                   // alarm record offered
   input wire logic i_alarm_ready,               // ladder controller takes record
   output logic [3:0] o_alarm_type,              // record type
   output logic [4:0] o_alarm_group,             // group number
   output logic [3:0] o_alarm_path,              // controller path
   output logic [3:0] o_alarm_slot,              // slot number
   output logic [3:0] o_alarm_info,              // alarm information number
   output logic [15:0] o_alarm_yaddr,            // output byte address of fault
   output logic [7:0] o_alarm_data,              // per-bit fault byte
   output logic o_alarm_safety                   // record refers to safety base
);
   // ********************************************
   // helper functions
   // ********************************************
   // lowest pending byte wins; later bytes wait their turn
   function automatic logic [1:0] pick_low(input logic [NBYTE-1:0] p);
      logic [1:0] r;
      r = 2'h0;
      for (int k = NBYTE - 1; k >= 0; k--) begin
         if (p[k]) begin
            r = 2'(k);
         end
      end
      return r;
   endfunction

   function automatic logic path_ok(input logic [3:0] p);
      return ((p >= OFSR_PATH_MIN) && (p <= OFSR_PATH_MAX)) || (p == OFSR_PATH_EXTRA);
   endfunction

   // ********************************************
   // declarations
   // ********************************************
   logic [NBYTE*8-1:0] trip;
   logic [NBYTE*8-1:0] flags_ff, nxt_flags, drive_ff, nxt_drive;
   logic [NBYTE-1:0] chg, pend_ff, nxt_pend, taken;
   logic [4:0] group_ff, nxt_group;
   logic [3:0] path_ff, nxt_path;
   logic safety_ff, nxt_safety;
   logic [15:0] base_ff, nxt_base, safe_base_ff, nxt_safe_base;
   logic [31:0] rdata_ff, nxt_rdata;
   ofsr_state_type state_ff, nxt_state;
   logic [1:0] sel;
   logic [7:0] sel_byte;
   logic [3:0] info_ff, nxt_info;
   logic [7:0] data_ff, nxt_data;
   logic [15:0] yaddr_ff, nxt_yaddr;
   logic rsafe_ff, nxt_rsafe;

   // ********************************************
   // driver protection and flags
   // ********************************************
   // either sensor trips the driver; there is no latch, so release restores it
   assign trip = i_ocp | i_otp;

   always_comb begin
      nxt_drive = i_do_cmd & ~trip;
      nxt_flags = trip;
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         drive_ff <= '0;
         flags_ff <= '0;
      end else begin
         drive_ff <= nxt_drive;
         flags_ff <= nxt_flags;
      end
   end

   // per-byte change detection, a new or cleared fault both re-report the byte
   for (genvar b = 0; b < NBYTE; b++) begin : g_chg
      assign chg[b] = nxt_flags[b*8 +: 8] != flags_ff[b*8 +: 8];
   end

   // ********************************************
   // register port
   // ********************************************
   // illegal group or path values are dropped so a record is never malformed
   always_comb begin
      nxt_group = group_ff;
      nxt_path = path_ff;
      nxt_safety = safety_ff;
      nxt_base = base_ff;
      nxt_safe_base = safe_base_ff;
      nxt_rdata = 32'h00000000;
      if (i_wr) begin
         case (i_addr)
            OFSR_ADDR_CFG: begin
               if (i_wdata[OFSR_GROUP_LSB +: 5] <= OFSR_GROUP_MAX) begin
                  nxt_group = i_wdata[OFSR_GROUP_LSB +: 5];
               end
               if (path_ok(i_wdata[OFSR_PATH_LSB +: 4])) begin
                  nxt_path = i_wdata[OFSR_PATH_LSB +: 4];
               end
               nxt_safety = i_wdata[OFSR_SAFETY_BIT];
            end
            OFSR_ADDR_BASE: nxt_base = i_wdata[15:0];
            OFSR_ADDR_SAFE_BASE: nxt_safe_base = i_wdata[15:0];
            default: nxt_base = base_ff;
         endcase
      end
      if (i_rd) begin
         case (i_addr)
            OFSR_ADDR_CFG: begin
               nxt_rdata[OFSR_GROUP_LSB +: 5] = group_ff;
               nxt_rdata[OFSR_PATH_LSB +: 4] = path_ff;
               nxt_rdata[OFSR_SAFETY_BIT] = safety_ff;
            end
            OFSR_ADDR_BASE: nxt_rdata[15:0] = base_ff;
            OFSR_ADDR_SAFE_BASE: nxt_rdata[15:0] = safe_base_ff;
            OFSR_ADDR_FLAGS: nxt_rdata[NBYTE*8-1:0] = flags_ff;
            OFSR_ADDR_PEND: nxt_rdata[NBYTE-1:0] = pend_ff;
            default: nxt_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         group_ff <= OFSR_GROUP_RST;
         path_ff <= OFSR_PATH_RST;
         safety_ff <= 1'b0;
         base_ff <= OFSR_BASE_RST;
         safe_base_ff <= OFSR_BASE_RST;
         rdata_ff <= 32'h00000000;
      end else begin
         group_ff <= nxt_group;
         path_ff <= nxt_path;
         safety_ff <= nxt_safety;
         base_ff <= nxt_base;
         safe_base_ff <= nxt_safe_base;
         rdata_ff <= nxt_rdata;
      end
   end

   // ********************************************
   // status alarm sequencer
   // ********************************************
   assign sel = pick_low(pend_ff);
   assign sel_byte = flags_ff[sel*8 +: 8];

   // info, data, address and safety bit are snapshotted at load; group and path stay live; a change after that re-arms the byte
   always_comb begin
      nxt_state = state_ff;
      taken = '0;
      nxt_info = info_ff;
      nxt_data = data_ff;
      nxt_yaddr = yaddr_ff;
      nxt_rsafe = rsafe_ff;
      case (state_ff)
         OFSR_ST_IDLE: begin
            if (pend_ff != '0) begin
               taken[sel] = 1'b1;
               nxt_info = OFSR_INFO_FIRST + {2'h0, sel};
               nxt_data = sel_byte;
               nxt_rsafe = safety_ff;
               nxt_yaddr = (safety_ff ? safe_base_ff : base_ff)
                           + {12'h000, OFSR_INFO_FIRST + {2'h0, sel}};
               nxt_state = OFSR_ST_SEND;
            end
         end
         OFSR_ST_SEND: begin
            if (i_alarm_ready) begin
               nxt_state = OFSR_ST_IDLE;
            end
         end
         default: nxt_state = OFSR_ST_IDLE;
      endcase
      // a change in the load cycle survives: set wins over clear
      nxt_pend = (pend_ff & ~taken) | chg;
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_ff <= OFSR_ST_IDLE;
         pend_ff <= '0;
         info_ff <= OFSR_INFO_FIRST;
         data_ff <= 8'h00;
         yaddr_ff <= OFSR_BASE_RST;
         rsafe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pend_ff <= nxt_pend;
         info_ff <= nxt_info;
         data_ff <= nxt_data;
         yaddr_ff <= nxt_yaddr;
         rsafe_ff <= nxt_rsafe;
      end
   end

   // ********************************************
   // outputs
   // ********************************************
   // no halt or error output exists: a fault only drops its own driver
   assign o_do_drive = drive_ff;
   assign o_fault_flags = flags_ff;
   assign o_rdata = rdata_ff;
   assign o_alarm_valid = (state_ff == OFSR_ST_SEND);
   assign o_alarm_type = OFSR_ALARM_TYPE;
   assign o_alarm_slot = OFSR_ALARM_SLOT;
   assign o_alarm_group = group_ff;
   assign o_alarm_path = path_ff;
   assign o_alarm_info = info_ff;
   assign o_alarm_yaddr = yaddr_ff;
   assign o_alarm_data = data_ff;
   assign o_alarm_safety = rsafe_ff;

   // ********************************************
   // assertions
   // ********************************************
   property p_trip_off;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (trip != '0) |=> ((o_do_drive & $past(trip)) == '0);
   endproperty
   a_trip_off: assert property (p_trip_off) else $error("tripped driver not off");
   // drivers keep following their command in cycles where no driver is tripped
   property p_healthy_follow;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (trip == '0) |=> (o_do_drive == $past(i_do_cmd));
   endproperty
   a_healthy_follow: assert property (p_healthy_follow) else $error("driver lost command");
   property p_hold_record;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (o_alarm_valid && !i_alarm_ready) |=> o_alarm_valid && $stable(o_alarm_data)
         && $stable(o_alarm_info);
   endproperty
   a_hold_record: assert property (p_hold_record) else $error("alarm record dropped");
   property p_report_soon;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (chg != '0) |=> ##[0:1] o_alarm_valid;
   endproperty
   a_report_soon: assert property (p_report_soon) else $error("fault not reported");
   property p_flag_sets;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (trip != '0) |=> ((o_fault_flags & $past(trip)) == $past(trip));
   endproperty
   a_flag_sets: assert property (p_flag_sets) else $error("fault flag not set");
   // address is checked at load, since software may move the base while a record waits
   property p_info_addr;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == OFSR_ST_IDLE) && (pend_ff != '0) && !safety_ff |=> (o_alarm_info >= 4'h5)
         && (o_alarm_info <= 4'h7) && (o_alarm_yaddr == $past(base_ff) + {12'h000, o_alarm_info});
   endproperty
   a_info_addr: assert property (p_info_addr) else $error("bad alarm number or address");
   property p_bitmap;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == OFSR_ST_IDLE && pend_ff != '0) |=> (o_alarm_data == $past(sel_byte));
   endproperty
   a_bitmap: assert property (p_bitmap) else $error("alarm byte mismatch");
   property p_record_fields;
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_alarm_valid |-> (o_alarm_type == 4'h0) && (o_alarm_slot == 4'h1)
         && (o_alarm_group <= 5'h17) && path_ok(o_alarm_path);
   endproperty
   a_record_fields: assert property (p_record_fields) else $error("bad record fields");
   property p_safety_addr;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == OFSR_ST_IDLE) && (pend_ff != '0) && safety_ff |=> o_alarm_safety
         && (o_alarm_yaddr == $past(safe_base_ff) + {12'h000, o_alarm_info});
   endproperty
   a_safety_addr: assert property (p_safety_addr) else $error("bad safety address");
   property p_flag_clears;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (trip == '0) ##1 (trip == '0) |-> (o_fault_flags == '0);
   endproperty
   a_flag_clears: assert property (p_flag_clears) else $error("fault flag stuck");

endmodule // ofsr_fault_report

// >>> ofsr_pkg.sv
// package of constants and types for the output fault status report block
package ofsr_pkg;
   // ********************************************
   // geometry of the supervised output bytes
   // ********************************************
   localparam int OFSR_NBYTE = 3;                  // bytes 5, 6 and 7 are supervised
   localparam logic [3:0] OFSR_INFO_FIRST = 4'h5;  // alarm information number of first byte
   // ********************************************
   // register offsets
   // ********************************************
   localparam logic [3:0] OFSR_ADDR_CFG = 4'h0;
   localparam logic [3:0] OFSR_ADDR_BASE = 4'h1;
   localparam logic [3:0] OFSR_ADDR_SAFE_BASE = 4'h2;
   localparam logic [3:0] OFSR_ADDR_FLAGS = 4'h3;
   localparam logic [3:0] OFSR_ADDR_PEND = 4'h4;
   // ********************************************
   // configuration fields and reset values
   // ********************************************
   localparam int OFSR_GROUP_LSB = 0;
   localparam int OFSR_PATH_LSB = 8;
   localparam int OFSR_SAFETY_BIT = 16;
   localparam logic [4:0] OFSR_GROUP_MAX = 5'h17;
   localparam logic [3:0] OFSR_PATH_MIN = 4'h1;
   localparam logic [3:0] OFSR_PATH_MAX = 4'h5;
   localparam logic [3:0] OFSR_PATH_EXTRA = 4'h9;
   localparam logic [4:0] OFSR_GROUP_RST = 5'h00;
   localparam logic [3:0] OFSR_PATH_RST = 4'h1;
   localparam logic [15:0] OFSR_BASE_RST = 16'h0000;
   // ********************************************
   // fixed fields of an alarm record
   // ********************************************
   localparam logic [3:0] OFSR_ALARM_TYPE = 4'h0;
   localparam logic [3:0] OFSR_ALARM_SLOT = 4'h1;
   // ********************************************
   // report sequencer states
   // ********************************************
   typedef enum logic [0:0] {
      OFSR_ST_IDLE = 1'b0,
      OFSR_ST_SEND = 1'b1
   } ofsr_state_type;
endpackage

// >>> ofsr_ladder_model.sv
// ladder controller model that takes status alarm records into its relay area
`timescale 1ns/100ps
module ofsr_ladder_model (
   input wire logic i_mclk,         // 10 MHz clock
   input wire logic i_sys_rst,      // async reset, active high
   input wire logic i_slow,         // take only one cycle in four
   input wire logic i_valid,        // record offered
   input wire logic [45:0] i_rec,   // record fields packed
   output logic o_ready             // record may be taken
);
   logic [1:0] slot_cnt_ff;
   logic [45:0] rec_mem_ff [0:15];
   int rec_count_ff;
   // a slow controller holds records off, so the sender must keep them whole
   assign o_ready = !i_slow || (slot_cnt_ff == 2'h3);
   // store each taken record as the system relay area would
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         slot_cnt_ff <= 2'h0;
         rec_count_ff <= 0;
      end else begin
         slot_cnt_ff <= slot_cnt_ff + 2'h1;
         if (i_valid && o_ready) begin
            rec_mem_ff[rec_count_ff[3:0]] <= i_rec;
            rec_count_ff <= rec_count_ff + 1;
         end
      end
   end
endmodule // ofsr_ladder_model

// >>> test_ofsr_fault_report.sv
// self-checking testbench of the output fault status report block
`timescale 1ns/100ps
module test_ofsr_fault_report;
   import ofsr_pkg::*;
   logic mclk, sys_rst, wr, rd, valid, ready, slow, safety;
   logic [3:0] addr, typ, path, slot, info;
   logic [4:0] group;
   logic [15:0] yaddr;
   logic [7:0] adata;
   logic [31:0] wdata, rdata, d;
   logic [23:0] cmd, ocp, otp, drive, flags;
   int err_total, checked, nrec;
   // ********************************************
   // clock, reset and instances
   // ********************************************
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   ofsr_fault_report i_ofsr_fault_report (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_do_cmd(cmd), .i_ocp(ocp),
      .i_otp(otp), .o_do_drive(drive), .o_fault_flags(flags), .o_alarm_valid(valid),
      .i_alarm_ready(ready), .o_alarm_type(typ), .o_alarm_group(group), .o_alarm_path(path),
      .o_alarm_slot(slot), .o_alarm_info(info), .o_alarm_yaddr(yaddr), .o_alarm_data(adata),
      .o_alarm_safety(safety));
   ofsr_ladder_model i_ofsr_ladder_model (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_slow(slow),
      .i_valid(valid), .i_rec({typ, group, path, slot, info, yaddr, adata, safety}),
      .o_ready(ready));
   // ********************************************
   // shared tasks
   // ********************************************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %0h expected %0h", $time, msg, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   // waits for the next record and compares it; group 23 and path 9 are set up first
   task automatic chk_rec(input logic [3:0] inf, input logic [15:0] ya, input logic [7:0] dat,
      input logic sf);
      for (int k = 0; k < 100 && i_ofsr_ladder_model.rec_count_ff <= nrec; k++) @(posedge mclk);
      chk(i_ofsr_ladder_model.rec_mem_ff[nrec], {4'h0, 5'h17, 4'h9, 4'h1, inf, ya, dat, sf},
         "alarm record");
      nrec++;
   endtask
   // ********************************************
   // scenarios
   // ********************************************
   task automatic test_cfg();
      #1;
      chk({valid, typ, slot, info}, {1'b0, 4'h0, 4'h1, 4'h5}, "record after reset");
      rd_reg(OFSR_ADDR_CFG, d);
      chk(d, 32'h0000_0100, "config reset");
      rd_reg(4'hF, d);
      chk(d, 32'h0, "unmapped read");
      wr_reg(OFSR_ADDR_CFG, 32'h0000_0917);
      // group 24 and path 6 are out of range and must leave the fields alone
      wr_reg(OFSR_ADDR_CFG, 32'h0000_0618);
      rd_reg(OFSR_ADDR_CFG, d);
      chk(d, 32'h0000_0917, "config range");
      wr_reg(OFSR_ADDR_BASE, 32'h0000_0100);
      wr_reg(OFSR_ADDR_SAFE_BASE, 32'h0000_0200);
      $display("test cfg done");
   endtask
   task automatic test_trip();
      // a checkerboard command shows that healthy drivers follow it, not a constant
      @(posedge mclk);
      ocp <= 24'h000008;
      cmd <= 24'h5A5A5A;
      @(posedge mclk);
      #1;
      chk(drive, 24'h5A5A52, "driver forced off, others run");
      chk(flags, 24'h000008, "live flags");
      rd_reg(OFSR_ADDR_FLAGS, d);
      chk(d, 32'h0000_0008, "flags register");
      chk_rec(4'h5, 16'h0105, 8'h08, 1'b0);
      @(posedge mclk);
      ocp <= 24'h0;
      chk_rec(4'h5, 16'h0105, 8'h00, 1'b0);
      chk({flags, drive}, {24'h0, 24'h5A5A5A}, "release");
      $display("test trip done");
   endtask
   task automatic test_multi();
      @(posedge mclk);
      slow <= 1'b1;
      otp <= 24'h018000;
      // both bytes are marked before the sequencer loads the first of them
      rd_reg(OFSR_ADDR_PEND, d);
      chk(d, 32'h0000_0006, "pending bytes");
      chk_rec(4'h6, 16'h0106, 8'h80, 1'b0);
      chk_rec(4'h7, 16'h0107, 8'h01, 1'b0);
      otp <= 24'h0;
      chk_rec(4'h6, 16'h0106, 8'h00, 1'b0);
      chk_rec(4'h7, 16'h0107, 8'h00, 1'b0);
      slow <= 1'b0;
      $display("test multi done");
   endtask
   task automatic test_safety();
      // a zero output base keeps the safety address free of the standard base
      wr_reg(OFSR_ADDR_BASE, 32'h0);
      wr_reg(OFSR_ADDR_CFG, 32'h0001_0917);
      ocp <= 24'h010000;
      chk_rec(4'h7, 16'h0207, 8'h01, 1'b1);
      ocp <= 24'h0;
      chk_rec(4'h7, 16'h0207, 8'h00, 1'b1);
      $display("test safety done");
   endtask
   // ********************************************
   // verdict, watchdog and main sequence
   // ********************************************
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // the tests need under a hundred cycles; ten thousand means a hang
   initial begin
      #1000000;
      err_total++;
      give_verdict();
   end
   initial begin
      {wr, rd, slow} = 3'b000;
      addr = 4'h0;
      wdata = 32'h0;
      cmd = 24'hFFFFFF;
      ocp = 24'h0;
      otp = 24'h0;
      {err_total, checked, nrec} = 0;
      sys_rst = 1'b1;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      test_cfg();
      test_trip();
      test_multi();
      test_safety();
      give_verdict();
   end
endmodule // test_ofsr_fault_report
